// ===== design/bctc_pkg.sv
// Package for the bus-cycle trace recorder: register map, record layout,
// bus status and area codes, timestamp rates.
// Assumes a 250 MHz system clock and a synchronous observed bus.
package bctc_pkg;

    localparam int CLK_NS = 4;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_DELAY    = 8'h04;
    localparam logic [7:0] REG_RANGE    = 8'h08;
    localparam logic [7:0] REG_STATUS   = 8'h0C;
    localparam logic [7:0] REG_INDEX    = 8'h10;
    localparam logic [7:0] REG_REC_ADDR = 8'h14;
    localparam logic [7:0] REG_REC_DATA = 8'h18;
    localparam logic [7:0] REG_REC_INFO = 8'h1C;

    // Control field positions
    localparam int CTRL_FREE    = 0;
    localparam int CTRL_RATE    = 4;
    localparam int CTRL_STOP    = 8;
    localparam int CTRL_DSTOP   = 9;
    localparam int CTRL_SMASK   = 12;
    localparam int CTRL_DMASK   = 16;
    localparam int RANGE_STRIDE = 8;

    // Bus clock count: 1 to 8, above that the overflow code
    localparam logic [3:0] CLK_MAX              = 4'h8;
    localparam logic [3:0] clock_count_overflow = 4'hF;

    // Timestamp rates; select 0 is disabled
    localparam logic [3:0] TS_RATE_LAST = 4'h9;
    localparam int TS_RATE_NS [1:9] = '{125, 250, 500, 1000, 2000, 4000, 8000, 16000, 100000};

    typedef enum logic [2:0] {
        AREA_ROM     = 3'h0,
        AREA_RAM     = 3'h1,
        AREA_IO8     = 3'h2,
        AREA_IO16    = 3'h3,
        AREA_EXT8    = 3'h4,
        AREA_EXT16   = 3'h5,
        AREA_XFR_RAM = 3'h6
    } bctc_area_t;

    typedef enum logic [2:0] {
        ST_XFER      = 3'h0,
        ST_PREFETCH  = 3'h1,
        ST_DATA      = 3'h2,
        ST_REFRESH   = 3'h3,
        ST_DMA       = 3'h4
    } bctc_status_t;

    typedef enum logic [1:0] {
        RNG_OFF   = 2'h0,
        RNG_RANGE = 2'h1,
        RNG_EVENT = 2'h2
    } bctc_rng_mode_t;

    typedef struct packed {
        logic [23:0]  addr;
        logic [15:0]  data;
        logic         wide;
        logic         write;
        bctc_area_t   area;
        bctc_status_t status;
    } bctc_bus_t;

    typedef struct packed {
        logic [3:0] probe;
        logic       nmi;
        logic [7:0] irq;
    } bctc_pins_t;

    typedef struct packed {
        bctc_area_t   area;
        bctc_status_t status;
        logic [3:0]   clocks;
        bctc_pins_t   pins;
    } bctc_info_t;

    typedef struct packed {
        logic        ts_mode;
        logic [23:0] addr;
        logic [15:0] data;
        logic        wide;
        logic        write;
        logic [31:0] info;
    } bctc_rec_t;

    function automatic logic [15:0] bctc_ts_cycles(logic [3:0] sel);
        int c;
        c = 1;
        if (sel != 4'h0 && sel <= TS_RATE_LAST) begin
            c = TS_RATE_NS[sel] / CLK_NS;
        end
        if (c < 1) begin
            c = 1;
        end
        return 16'(c);
    endfunction

endpackage

// ===== design/bctc_recorder.sv
// Bus-cycle trace recorder: one record per observed bus cycle into a
// circular buffer, read back through a plain register port.
// Assumes bus and pin inputs synchronous to clk_sys; event matches are
// produced outside and are valid in the cycle that bus_done is high.
//
// Function
// - With no acquisition condition, every observed bus cycle is recorded.
// - Free mode records from program start until the program halts or an enabled stop fires.
// - A full buffer overwrites its oldest record; the buffer is circular.
// - Index zero is the newest record, older ones take negative indices.
// - With delayed stop, index zero is the matching cycle; later ones positive.
// - Each record holds the 24-bit bus address.
// - Each record holds byte or halfword data with its width.
// - Each record flags read or write.
// - Each record classifies the accessed memory area.
// - Each record holds the bus status of the cycle.
// - Each record counts bus clocks 1 to 8, else an overflow code.
// - Each record samples probes, probe four in the top bit.
// - Each record samples the NMI level and eight IRQ levels.
// - The timestamp restarts from zero at every program start.
// - The timestamp advances at the selected tick rate.
// - With timestamps on, timestamp replaces area, status, clocks, probes, NMI, IRQs.
// - Conditional capture lets event matches start, stop and end tracing.
// - Four range channels act only while free mode is off.
// - Stop can be immediate on a match, or delayed after one.
// - The delay counts bus cycles, one through 65535.
// - The timestamp wraps to zero on overflow and keeps counting.
// - The buffer holds 32768 records of the latest run.
`timescale 1ns/1ns
module bctc_recorder #(
    parameter int DEPTH   = 32768,
    parameter int CHANNELS = 4
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // Observed bus
    input  wire logic              bus_done,
    input  wire logic              bus_clk_tick,
    input  wire bctc_pkg::bctc_bus_t  bus_cycle,
    input  wire bctc_pkg::bctc_pins_t pins,
    // Program and events
    input  wire logic              prefetch_status_run,
    input  wire logic [3:0]        event_match,
    // Register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata,
    // Status
    output logic                   trace_active
);
    import bctc_pkg::*;

    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || AW > 16 || CHANNELS != 4) begin
            $error("bctc_recorder: DEPTH must be a power of two up to 65536, CHANNELS 4");
        end
    end

    typedef struct packed {
        logic          free_mode;
        logic [3:0]    ts_rate;
        logic          stop_en;
        logic          dstop_en;
        logic [3:0]    stop_mask;
        logic [3:0]    dstop_mask;
        logic [15:0]   delay;
        logic [31:0]   range_cfg;
        logic [15:0]   index;
        logic          run_q;
        logic          active;
        logic          stopped;
        logic          wrapped;
        logic          dfired;
        logic [15:0]   dleft;
        logic [AW-1:0] wptr;
        logic [AW-1:0] origin;
        logic [3:0]    win;
        logic [3:0]    clks;
        logic [15:0]   ts_div;
        logic [31:0]   ts;
        logic [31:0]   rd_data;
    } bctc_state_t;

    bctc_state_t st;
    bctc_state_t next_st;

    bctc_rec_t   mem [DEPTH];
    bctc_rec_t   mem_q;
    bctc_rec_t   rec;
    logic        we;
    logic [AW-1:0] rd_ptr;

    logic [3:0]  ev;
    logic [3:0]  hit;
    logic [3:0]  win_nxt;
    logic [3:0]  enabled;

    ////////////////////////////////////////////////////////////////
    // Range channels

    assign ev = event_match & {4{bus_done}};

    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_rng
            bctc_rng_mode_t mode;
            logic [1:0]     start_sel;
            logic [1:0]     stop_sel;
            logic           start_hit;
            logic           stop_hit;
            assign mode      = bctc_rng_mode_t'(st.range_cfg[gi*RANGE_STRIDE +: 2]);
            assign start_sel = st.range_cfg[gi*RANGE_STRIDE+2 +: 2];
            assign stop_sel  = st.range_cfg[gi*RANGE_STRIDE+4 +: 2];
            assign start_hit = ev[start_sel];
            assign stop_hit  = ev[stop_sel];
            assign enabled[gi] = (mode != RNG_OFF);
            // Range mode keeps only cycles matching its own start event
            assign hit[gi] = (mode == RNG_RANGE) ? start_hit :
                             (mode == RNG_EVENT) ? (st.win[gi] | start_hit) : 1'b0;
            // The stop cycle itself is still recorded, then the window closes
            assign win_nxt[gi] = (mode != RNG_EVENT) ? 1'b0 :
                                 stop_hit ? 1'b0 :
                                 start_hit ? 1'b1 : st.win[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic        run_rise;
        logic        gate;
        logic        cap;
        logic [3:0]  cnt;
        logic [15:0] ts_cyc;
        logic        ts_on;
        bctc_info_t  info;
        run_rise = 1'b0;
        gate     = 1'b0;
        cap      = 1'b0;
        cnt      = 4'h0;
        ts_cyc   = 16'h0000;
        ts_on    = 1'b0;
        info     = '0;
        next_st  = st;
        rec      = '0;
        we       = 1'b0;

        run_rise       = prefetch_status_run & ~st.run_q;
        next_st.run_q  = prefetch_status_run;

        // Register writes
        if (reg_wr) begin
            if (reg_addr == REG_CTRL) begin
                next_st.free_mode  = reg_wdata[CTRL_FREE];
                next_st.ts_rate    = reg_wdata[CTRL_RATE +: 4];
                next_st.stop_en    = reg_wdata[CTRL_STOP];
                next_st.dstop_en   = reg_wdata[CTRL_DSTOP];
                next_st.stop_mask  = reg_wdata[CTRL_SMASK +: 4];
                next_st.dstop_mask = reg_wdata[CTRL_DMASK +: 4];
            end else if (reg_addr == REG_DELAY) begin
                next_st.delay = reg_wdata[15:0];
            end else if (reg_addr == REG_RANGE) begin
                next_st.range_cfg = reg_wdata;
            end else if (reg_addr == REG_INDEX) begin
                next_st.index = reg_wdata[15:0];
            end
        end

        // Clocks in the current bus cycle, held at nine once past eight
        cnt = st.clks + {3'h0, bus_clk_tick};
        if (cnt > CLK_MAX + 4'h1) begin
            cnt = CLK_MAX + 4'h1;
        end
        next_st.clks = bus_done ? 4'h0 : cnt;

        // Timestamp tick
        ts_on  = (st.ts_rate != 4'h0) && (st.ts_rate <= TS_RATE_LAST);
        ts_cyc = bctc_ts_cycles(st.ts_rate);
        if (ts_on) begin
            if (st.ts_div >= ts_cyc - 16'h0001) begin
                next_st.ts_div = 16'h0000;
                next_st.ts     = st.ts + 32'h0000_0001;
            end else begin
                next_st.ts_div = st.ts_div + 16'h0001;
            end
        end

        // Capture gate: free mode ignores channels
        if (st.free_mode || enabled == 4'h0) begin
            gate = 1'b1;
        end else begin
            gate = |(hit & enabled);
        end
        cap = st.active && bus_done && gate;

        // Record assembly
        info.area   = bus_cycle.area;
        info.status = bus_cycle.status;
        info.clocks = (cnt > CLK_MAX) ? clock_count_overflow : cnt;
        info.pins   = pins;
        rec.ts_mode = ts_on;
        rec.addr    = bus_cycle.addr;
        rec.data    = bus_cycle.wide ? bus_cycle.data : {8'h00, bus_cycle.data[7:0]};
        rec.wide    = bus_cycle.wide;
        rec.write   = bus_cycle.write;
        rec.info    = ts_on ? st.ts : {9'h000, info};

        if (cap) begin
            we           = 1'b1;
            next_st.wptr = st.wptr + AW'(1);
            if (st.wptr == AW'(DEPTH - 1)) begin
                next_st.wrapped = 1'b1;
            end
        end

        // Stop handling
        if (st.active && bus_done) begin
            if (st.dfired) begin
                if (st.dleft <= 16'h0001) begin
                    next_st.dleft  = 16'h0000;
                    next_st.active = 1'b0;
                    next_st.stopped = 1'b1;
                end else begin
                    next_st.dleft = st.dleft - 16'h0001;
                end
            end else if (st.dstop_en && |(ev & st.dstop_mask)) begin
                next_st.dfired = 1'b1;
                next_st.origin = st.wptr;
                next_st.dleft  = (st.delay == 16'h0000) ? 16'h0001 : st.delay;
            end
            // An immediate stop wins over a pending delay
            if (st.stop_en && |(ev & st.stop_mask)) begin
                next_st.active  = 1'b0;
                next_st.stopped = 1'b1;
            end
        end

        if (cap || !st.active) begin
            next_st.win = win_nxt;
        end

        // Halt ends capture
        if (!prefetch_status_run) begin
            next_st.active = 1'b0;
        end

        // New run clears buffer history and timestamp
        if (run_rise) begin
            next_st.active  = 1'b1;
            next_st.stopped = 1'b0;
            next_st.wrapped = 1'b0;
            next_st.dfired  = 1'b0;
            next_st.dleft   = 16'h0000;
            next_st.wptr    = '0;
            next_st.origin  = '0;
            next_st.win     = 4'h0;
            next_st.ts      = 32'h0000_0000;
            next_st.ts_div  = 16'h0000;
        end

        // Register reads, answered in the next cycle only
        next_st.rd_data = 32'h0000_0000;
        if (reg_rd) begin
            if (reg_addr == REG_CTRL) begin
                next_st.rd_data[CTRL_FREE]       = st.free_mode;
                next_st.rd_data[CTRL_RATE +: 4]  = st.ts_rate;
                next_st.rd_data[CTRL_STOP]       = st.stop_en;
                next_st.rd_data[CTRL_DSTOP]      = st.dstop_en;
                next_st.rd_data[CTRL_SMASK +: 4] = st.stop_mask;
                next_st.rd_data[CTRL_DMASK +: 4] = st.dstop_mask;
            end else if (reg_addr == REG_DELAY) begin
                next_st.rd_data[15:0] = st.delay;
            end else if (reg_addr == REG_RANGE) begin
                next_st.rd_data = st.range_cfg;
            end else if (reg_addr == REG_STATUS) begin
                next_st.rd_data[0]           = st.active;
                next_st.rd_data[1]           = st.stopped;
                next_st.rd_data[2]           = st.wrapped;
                next_st.rd_data[3]           = st.dfired;
                next_st.rd_data[16 +: AW]    = st.wptr;
            end else if (reg_addr == REG_INDEX) begin
                next_st.rd_data[15:0] = st.index;
            end else if (reg_addr == REG_REC_ADDR) begin
                next_st.rd_data[23:0] = mem_q.addr;
                next_st.rd_data[24]   = mem_q.write;
                next_st.rd_data[25]   = mem_q.wide;
                next_st.rd_data[26]   = mem_q.ts_mode;
            end else if (reg_addr == REG_REC_DATA) begin
                next_st.rd_data[15:0] = mem_q.data;
            end else if (reg_addr == REG_REC_INFO) begin
                next_st.rd_data = mem_q.info;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Index to buffer slot, taken from the next state so a read may
    // follow an index write directly

    always_comb begin
        logic [AW-1:0] base;
        base = '0;
        if (next_st.dfired) begin
            base = next_st.origin;
        end else begin
            base = next_st.wptr - AW'(1);
        end
        rd_ptr = base + next_st.index[AW-1:0];
    end

    ////////////////////////////////////////////////////////////////
    // Registers and trace memory

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st           <= '0;
            st.free_mode <= 1'b1;
            st.delay     <= 16'h0001;
        end else begin
            st <= next_st;
        end
    end

    // Memory has no reset; a record is only read after it is written
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[st.wptr] <= rec;
        end
        mem_q <= mem[rd_ptr];
    end

    assign reg_rdata    = st.rd_data;
    assign trace_active = st.active;

endmodule

// ===== verif/bctc_bus_model.sv
// Model of the observed target bus: bus cycles, pins, events, run line.
// Driven through its tasks, called right after a rising clock edge.
`timescale 1ns/1ns
module bctc_bus_model
    import bctc_pkg::*;
(
    // Clock
    input wire logic   clk_sys,
    // Observed bus
    output logic       bus_done,
    output logic       bus_clk_tick,
    output bctc_bus_t  bus_cycle,
    output bctc_pins_t pins,
    output logic [3:0] event_match,
    // Program control
    output logic       prefetch_status_run
);
    initial begin
        bus_done     = 1'b0;
        bus_clk_tick = 1'b0;
        bus_cycle    = '1;
        pins         = '1;
        event_match  = 4'hF;
        prefetch_status_run     = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Fields show garbage outside the done cycle, so stale sampling is caught
    // Ticks on every other edge, so the count is of ticks, not of edges
    task automatic cycle(input bctc_bus_t b, input bctc_pins_t p, input int n, input logic [3:0] ev);
        for (int i = 1; i < 2 * n - 1; i++) begin
            bus_clk_tick <= i[0];
            @(posedge clk_sys);
        end
        bus_clk_tick <= 1'b1;
        bus_cycle   <= b;
        pins        <= p;
        event_match <= ev;
        bus_done    <= 1'b1;
        @(posedge clk_sys);
        bus_done     <= 1'b0;
        bus_clk_tick <= 1'b0;
        bus_cycle    <= ~b;
        pins         <= ~p;
        event_match  <= ~ev;
        @(posedge clk_sys);
    endtask

    task automatic run(input logic on);
        prefetch_status_run <= on;
        repeat (2) @(posedge clk_sys);
    endtask
endmodule

// ===== verif/bctc_recorder_assertions.sv
// Checker for the trace recorder: run control and register readback.
// Sees only the recorder's ports; attached by the bind at the foot.
`timescale 1ns/1ns
module bctc_recorder_assertions
    import bctc_pkg::*;
#(
    parameter int DEPTH = 32768
) (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // Observed side
    input wire logic        bus_done,
    input wire logic        prefetch_status_run,
    // Register port
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Status
    input wire logic        trace_active
);
    logic [15:0] delay_q;
    logic [31:0] ctrl_q;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////////
    // Shadows of two writable registers, kept from the port traffic alone
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            delay_q <= 16'h0001;
            ctrl_q  <= 32'h0000_0001;
        end else if (reg_wr && reg_addr == REG_DELAY) begin
            delay_q <= reg_wdata[15:0];
        end else if (reg_wr && reg_addr == REG_CTRL) begin
            ctrl_q <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_halt_drops_active: assert property (!prefetch_status_run |=> !trace_active)
        else $error("capture still active after halt");
    a_start_arms_active: assert property ($rose(prefetch_status_run) |=> trace_active)
        else $error("capture not armed after program start");
    a_active_needs_run: assert property (trace_active |-> $past(prefetch_status_run))
        else $error("capture active without a running program");
    a_rearm_on_start: assert property ($rose(trace_active) |-> $past(prefetch_status_run) && !$past(prefetch_status_run, 2))
        else $error("capture re-armed without a program start");
    a_free_stays_on: assert property (ctrl_q[0] && ctrl_q[9:8] == 2'b00 && $past(prefetch_status_run) && prefetch_status_run
                                      |-> trace_active)
        else $error("free capture without stops went inactive");
    a_status_mirror: assert property (reg_rd && reg_addr == REG_STATUS |=> reg_rdata[0] == $past(trace_active))
        else $error("status active bit differs from capture state");
    a_ptr_in_depth: assert property (reg_rd && reg_addr == REG_STATUS |=> int'(reg_rdata[30:16]) < DEPTH)
        else $error("write pointer beyond buffer depth");
    a_delay_readback: assert property (reg_rd && reg_addr == REG_DELAY |=> reg_rdata[15:0] == $past(delay_q))
        else $error("delay register readback wrong");

    c_start: cover property ($rose(trace_active));
    c_capture: cover property (bus_done && trace_active);
    c_stop_in_run: cover property ($fell(trace_active) && prefetch_status_run);
endmodule

bind bctc_recorder bctc_recorder_assertions #(.DEPTH(DEPTH)) i_bctc_recorder_assertions (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus_done(bus_done), .prefetch_status_run(prefetch_status_run),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trace_active(trace_active));

// ===== verif/test_bctc_recorder.sv
// Self-checking bench for the trace recorder: register tasks, bus model
// on the observed side. Buffer shrunk to 8 records to reach the wrap.
`timescale 1ns/1ns
module test_bctc_recorder;
    import bctc_pkg::*;
    localparam int DEPTH = 8;
    logic        clk_sys;
    logic        rst_n;
    logic        bus_done;
    logic        bus_clk_tick;
    bctc_bus_t   bus_cycle;
    bctc_pins_t  pins;
    logic        prefetch_status_run;
    logic [3:0]  event_match;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        trace_active;
    int          mismatches;
    int          cmp_count;
    bctc_bus_t   eb [10];
    bctc_pins_t  ep [10];
    logic [31:0] d;

    bctc_recorder #(.DEPTH(DEPTH), .CHANNELS(4)) i_bctc_recorder (.clk_sys(clk_sys), .rst_n(rst_n),
        .bus_done(bus_done), .bus_clk_tick(bus_clk_tick), .bus_cycle(bus_cycle), .pins(pins),
        .prefetch_status_run(prefetch_status_run), .event_match(event_match), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trace_active(trace_active));
    bctc_bus_model i_bctc_bus_model (.clk_sys(clk_sys), .bus_done(bus_done), .bus_clk_tick(bus_clk_tick),
        .bus_cycle(bus_cycle), .pins(pins), .event_match(event_match), .prefetch_status_run(prefetch_status_run));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One strobe cycle; data stand only in the cycle after it, taken mid-cycle
    task automatic access(input logic w, input logic [7:0] a, input logic [31:0] wv, output logic [31:0] v);
        reg_addr  <= a;
        reg_wdata <= wv;
        reg_wr    <= w;
        reg_rd    <= ~w;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        v = reg_rdata;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] ignored;
        access(1'b1, a, v, ignored);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        access(1'b0, a, 32'h0, v);
    endtask

    task automatic rec(input logic [15:0] idx, input int k);
        logic [3:0] c;
        c = (k >= 8) ? 4'hF : 4'(k + 1);
        wr(REG_INDEX, {16'h0, idx});
        rd(REG_REC_ADDR, d);
        check(d, {5'h0, 1'b0, eb[k].wide, eb[k].write, eb[k].addr});
        rd(REG_REC_DATA, d);
        check(d, {16'h0, eb[k].wide ? eb[k].data : {8'h0, eb[k].data[7:0]}});
        rd(REG_REC_INFO, d);
        check(d, {9'h0, eb[k].area, eb[k].status, c, ep[k]});
    endtask

    task automatic burst(input int n, input logic [9:0] hits, input logic [3:0] ev);
        for (int k = 0; k < n; k++) begin
            i_bctc_bus_model.cycle(eb[k], ep[k], k + 1, hits[k] ? ev : 4'h0);
        end
    endtask

    task automatic status(input logic [31:0] mask, input logic [31:0] exp);
        rd(REG_STATUS, d);
        check(d & mask, exp);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Hang guard, far beyond the roughly 700 cycles the tests take
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        mismatches = 0;
        cmp_count = 0;
        for (int k = 0; k < 10; k++) begin
            eb[k].addr = 24'h800000 ^ 24'(k * 4369);
            eb[k].data = 16'hA5C3 ^ 16'(k * 771);
            eb[k].wide = k[0];
            eb[k].write = k[1];
            eb[k].area = bctc_area_t'(3'(k % 7));
            eb[k].status = bctc_status_t'(3'(k % 5));
            ep[k] = '{probe: 4'(k), nmi: k[2], irq: 8'h01 << (k % 8)};
        end
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd(REG_CTRL, d);
        check(d, 32'h0000_0001);
        rd(REG_DELAY, d);
        check(d, 32'h0000_0001);
        wr(REG_STATUS, 32'hFFFF_FFFF);
        status(32'hFFFF_FFFF, 32'h0);
        rd(8'h20, d);
        check(d, 32'h0);
        $display("register test done");
        // Ten cycles into eight slots: wrap, then a cycle after halt
        i_bctc_bus_model.run(1'b1);
        burst(10, 10'h000, 4'h0);
        i_bctc_bus_model.run(1'b0);
        i_bctc_bus_model.cycle(eb[0], ep[0], 1, 4'h0);
        status(32'h7FFF_0005, 32'h0002_0004);
        for (int j = 0; j < 8; j++) begin
            rec(16'(-j), 9 - j);
        end
        $display("free capture test done");
        wr(REG_CTRL, 32'h0000_1101);
        i_bctc_bus_model.run(1'b1);
        burst(5, 10'h004, 4'h1);
        status(32'h7FFF_0003, 32'h0003_0002);
        i_bctc_bus_model.run(1'b0);
        $display("immediate stop test done");
        wr(REG_DELAY, 32'h0000_0002);
        wr(REG_CTRL, 32'h0001_0201);
        i_bctc_bus_model.run(1'b1);
        burst(8, 10'h008, 4'h1);
        status(32'h7FFF_0008, 32'h0006_0008);
        i_bctc_bus_model.run(1'b0);
        rec(16'h0000, 3);
        rec(16'h0002, 5);
        rec(16'hFFFF, 2);
        $display("delayed stop test done");
        wr(REG_RANGE, 32'h0000_0005);
        for (int f = 1; f >= 0; f--) begin
            wr(REG_CTRL, {31'h0, f[0]});
            i_bctc_bus_model.run(1'b1);
            burst(4, 10'h00A, 4'h2);
            i_bctc_bus_model.run(1'b0);
            status(32'h7FFF_0000, f ? 32'h0004_0000 : 32'h0002_0000);
        end
        rec(16'h0000, 3);
        // Start/stop window: opens on event 1, closes after the event 0 cycle
        wr(REG_RANGE, 32'h0000_0006);
        i_bctc_bus_model.run(1'b1);
        for (int k = 0; k < 5; k++) begin
            i_bctc_bus_model.cycle(eb[k], ep[k], k + 1, (k == 1) ? 4'h2 : (k == 3) ? 4'h1 : 4'h0);
        end
        i_bctc_bus_model.run(1'b0);
        status(32'h7FFF_0000, 32'h0003_0000);
        rec(16'hFFFE, 1);
        $display("range test done");
        // Second run must not carry the first run's count
        wr(REG_CTRL, 32'h0000_0011);
        for (int r = 0; r < 2; r++) begin
            i_bctc_bus_model.run(1'b1);
            repeat (96) @(posedge clk_sys);
            i_bctc_bus_model.cycle(eb[0], ep[0], 1, 4'h0);
            i_bctc_bus_model.run(1'b0);
            wr(REG_INDEX, 32'h0);
            rd(REG_REC_ADDR, d);
            check({31'h0, d[26]}, 32'h1);
            rd(REG_REC_INFO, d);
            check({31'h0, d >= 32'd2 && d <= 32'd4}, 32'h1);
        end
        $display("timestamp test done");
        tally_and_finish();
    end
endmodule
